// File: mfpc_pkg.sv
// constants for the multi-function pin control block
package mfpc_pkg;
    // ==================================================
    // register indices and bus address width
    localparam logic [7:0] REG_IDX_PAD     = 8'h09;
    localparam logic [7:0] REG_IDX_CFG_A   = 8'h14;
    localparam logic [7:0] REG_IDX_CFG_B   = 8'h15;
    localparam logic [7:0] REG_IDX_SHARED  = 8'h16;
    localparam logic [7:0] REG_IDX_POL     = 8'h17;
    localparam logic [7:0] REG_IDX_STATUS  = 8'h18;
    localparam logic [7:0] REG_IDX_MASK    = 8'h19;
    localparam logic [7:0] REG_IDX_MISC    = 8'h1a;
    localparam int         ADDR_W          = 10;
    // ==================================================
    // field positions, widths and pin counts
    localparam int TRIS_BIT     = 13;
    localparam int SEL_W        = 4;
    localparam int CFG_LO_BASE  = 0;
    localparam int CFG_HI_BASE  = 8;
    localparam int F_SEL        = 0;
    localparam int F_PD         = 4;
    localparam int F_PU         = 5;
    localparam int F_IRQ        = 6;
    localparam int F_DEB        = 7;
    localparam int SH_FIRST     = 0;
    localparam int SH_SECOND    = 4;
    localparam int SH_ENA       = 0;
    localparam int SH_IRQ       = 2;
    localparam int SH_DEB       = 3;
    localparam int POL_W        = 8;
    localparam int NPIN         = 5;
    localparam int NDED         = 3;
    // polarity bit for each pin index: ded3, ded4, ded5, first, second
    localparam logic [4:0][2:0] POL_BIT = {3'd7, 3'd6, 3'd4, 3'd3, 3'd2};
    // ==================================================
    // reset values and writable-bit masks
    localparam logic [15:0] RST_PAD    = 16'h0000;
    localparam logic [15:0] RST_CFG_A  = 16'h1010;
    localparam logic [15:0] RST_CFG_B  = 16'h0010;
    localparam logic [15:0] RST_SHARED = 16'h0000;
    localparam logic [15:0] RST_POL    = 16'h0000;
    localparam logic [15:0] POL_MASK   = 16'h00dc;
    localparam logic [15:0] CFGB_MASK  = 16'h00ff;
    localparam logic [15:0] SH_MASK    = 16'h00dd;
    // ==================================================
    // de-bounce: stable input for this many slow ticks
    localparam logic [2:0] DEB_TICKS   = 3'd4;
    // ==================================================
    // pin function codes
    typedef enum logic [3:0] {
        FN_INPUT    = 4'h0,
        FN_CLK_OUT  = 4'h1,
        FN_LOW      = 4'h2,
        FN_HIGH     = 4'h3,
        FN_PLL_LOCK = 4'h4,
        FN_TEMP_OK  = 4'h5,
        FN_READBACK = 4'h6,
        FN_IRQ      = 4'h7,
        FN_MIC_DET  = 4'h8,
        FN_MIC_SHRT = 4'h9
    } mfpc_func_t;
endpackage : mfpc_pkg

// File: mfpc_top.sv
// multi-function pin control: pads, de-bounce, detect latching, avalon regs
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/1ps
module mfpc_top
    import mfpc_pkg::*;
(
    // clock and reset
    input  wire logic              core_clk_in,
    input  wire logic              reset_in,
    // avalon-mm slave
    input  wire logic [ADDR_W-1:0] avs_address_in,
    input  wire logic              avs_read_in,
    input  wire logic              avs_write_in,
    input  wire logic [31:0]       avs_writedata_in,
    input  wire logic [3:0]        avs_byteenable_in,
    output logic      [31:0]       avs_readdata_out,
    output logic                   avs_waitrequest_out,
    // function sources
    input  wire logic              system_clock_div_in,
    input  wire logic              pll_lock_in,
    input  wire logic              temp_ok_in,
    input  wire logic              readback_serial_out_in,
    input  wire logic              device_irq_in,
    input  wire logic              mic_detect_in,
    input  wire logic              mic_short_in,
    input  wire logic              slow_tick_in,
    // dedicated pins (index 0..2 = three, four, five)
    input  wire logic [NDED-1:0]   ded_pin_in,
    output logic      [NDED-1:0]   ded_pin_out,
    output logic      [NDED-1:0]   ded_pin_oe_out,
    output logic      [NDED-1:0]   ded_pullup_out,
    output logic      [NDED-1:0]   ded_pulldown_out,
    // shared pins (0 = first, 1 = second)
    input  wire logic [1:0]        shared_pin_in,
    // global audio pad tristate and interrupt
    output logic                   audio_pad_tristate_out,
    output logic                   irq_out
);
    // ==================================================
    // decode helpers
    function automatic logic [7:0] pin_cfg(input logic [15:0] a,
                                           input logic [15:0] b,
                                           input int          i);
        logic [7:0] r;
        r = 8'h00;
        case (i)
            0:       r = a[CFG_LO_BASE +: 8];
            1:       r = a[CFG_HI_BASE +: 8];
            default: r = b[CFG_LO_BASE +: 8];
        endcase
        return r;
    endfunction : pin_cfg

    function automatic logic [15:0] wmerge(input logic [15:0] old,
                                           input logic [31:0] d,
                                           input logic [3:0]  be,
                                           input logic [15:0] m);
        logic [15:0] r;
        r = old;
        if (be[0]) begin
            r[7:0] = d[7:0];
        end
        if (be[1]) begin
            r[15:8] = d[15:8];
        end
        return r & m;
    endfunction : wmerge

    // ==================================================
    // registers
    logic [15:0]     audio_pad_control;
    logic [15:0]     pin_config_a;
    logic [15:0]     pin_config_b;
    logic [15:0]     shared_input_config;
    logic [15:0]     input_polarity;
    logic [NPIN-1:0] irq_status;
    logic [NPIN-1:0] irq_mask;
    logic            slow_tick_clock_enable;

    // ==================================================
    // bus decode
    wire logic [7:0] reg_idx  = avs_address_in[ADDR_W-1:2];
    wire logic       hit_pad  = reg_idx == REG_IDX_PAD;
    wire logic       hit_a    = reg_idx == REG_IDX_CFG_A;
    wire logic       hit_b    = reg_idx == REG_IDX_CFG_B;
    wire logic       hit_sh   = reg_idx == REG_IDX_SHARED;
    wire logic       hit_pol  = reg_idx == REG_IDX_POL;
    wire logic       hit_st   = reg_idx == REG_IDX_STATUS;
    wire logic       hit_mask = reg_idx == REG_IDX_MASK;
    wire logic       hit_misc = reg_idx == REG_IDX_MISC;
    wire logic       wr       = avs_write_in;
    wire logic       rd_st    = avs_read_in && hit_st;

    // no wait states
    assign avs_waitrequest_out = 1'b0;

    wire logic [31:0] next_readdata =
        hit_pad  ? {16'h0000, audio_pad_control}   :
        hit_a    ? {16'h0000, pin_config_a}        :
        hit_b    ? {16'h0000, pin_config_b}        :
        hit_sh   ? {16'h0000, shared_input_config} :
        hit_pol  ? {16'h0000, input_polarity}      :
        hit_st   ? {27'h0, irq_status}             :
        hit_mask ? {27'h0, irq_mask}               :
        hit_misc ? {31'h0, slow_tick_clock_enable} : 32'h0000_0000;

    // combinational read data: valid at the edge that takes the read
    assign avs_readdata_out = avs_read_in ? next_readdata : 32'h0000_0000;

    // ==================================================
    // write strobes and merged write values
    wire logic        wr_pad   = wr && hit_pad;
    wire logic        wr_a     = wr && hit_a;
    wire logic        wr_b     = wr && hit_b;
    wire logic        wr_sh    = wr && hit_sh;
    wire logic        wr_pol   = wr && hit_pol;
    wire logic        wr_mask  = wr && hit_mask && avs_byteenable_in[0];
    wire logic        wr_misc  = wr && hit_misc && avs_byteenable_in[0];

    // merged write data, reserved bits cleared
    wire logic [15:0] next_pad = wmerge(audio_pad_control,
        avs_writedata_in, avs_byteenable_in, '1);
    wire logic [15:0] next_a   = wmerge(pin_config_a,
        avs_writedata_in, avs_byteenable_in, '1);
    wire logic [15:0] next_b   = wmerge(pin_config_b,
        avs_writedata_in, avs_byteenable_in, CFGB_MASK);
    wire logic [15:0] next_sh  = wmerge(shared_input_config,
        avs_writedata_in, avs_byteenable_in, SH_MASK);
    wire logic [15:0] next_pol = wmerge(input_polarity,
        avs_writedata_in, avs_byteenable_in, POL_MASK);

    // pad control
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            audio_pad_control <= RST_PAD;
        end else if (wr_pad) begin
            audio_pad_control <= next_pad;
        end
    end

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            pin_config_a <= RST_CFG_A;
        end else if (wr_a) begin
            pin_config_a <= next_a;
        end
    end

    // pin five config
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            pin_config_b <= RST_CFG_B;
        end else if (wr_b) begin
            pin_config_b <= next_b;
        end
    end

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            shared_input_config <= RST_SHARED;
        end else if (wr_sh) begin
            shared_input_config <= next_sh;
        end
    end

    // input polarity
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            input_polarity <= RST_POL;
        end else if (wr_pol) begin
            input_polarity <= next_pol;
        end
    end

    // interrupt mask
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            irq_mask <= '0;
        end else if (wr_mask) begin
            irq_mask <= avs_writedata_in[NPIN-1:0];
        end
    end

    // slow tick enable
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            slow_tick_clock_enable <= 1'b0;
        end else if (wr_misc) begin
            slow_tick_clock_enable <= avs_writedata_in[0];
        end
    end

    // ==================================================
    // per-pin control fields
    logic [NPIN-1:0] raw_pin;
    logic [NPIN-1:0] deb_en;
    logic [NPIN-1:0] irq_en;
    logic [NPIN-1:0] in_active;
    logic [NPIN-1:0] pol_inv;

    assign raw_pin = {shared_pin_in, ded_pin_in};
    wire logic tris_all = audio_pad_control[TRIS_BIT];
    assign audio_pad_tristate_out = tris_all;

    // ==================================================
    // de-bounce tick
    // tick needs enable bit
    wire logic tick = slow_tick_in && slow_tick_clock_enable;

    // ==================================================
    // dedicated pin drivers
    genvar g;
    generate
        for (g = 0; g < NDED; g++) begin : g_ded
            wire logic [7:0] cfg  = pin_cfg(pin_config_a, pin_config_b, g);
            wire logic [3:0] sel  = cfg[F_SEL +: SEL_W];
            wire logic       pu   = cfg[F_PU];
            wire logic       pd   = cfg[F_PD];
            wire logic       pull = pu | pd;
            wire logic       free = !pull && !tris_all;
            logic            drv;
            logic            val;
            always_comb begin
                drv = 1'b1;
                val = 1'b0;
                case (sel)
                    FN_CLK_OUT:  val = system_clock_div_in;
                    FN_LOW:      val = 1'b0;
                    FN_HIGH:     val = 1'b1;
                    FN_PLL_LOCK: val = pll_lock_in;
                    FN_TEMP_OK:  val = temp_ok_in;
                    FN_READBACK: val = readback_serial_out_in;
                    FN_IRQ:      val = device_irq_in;
                    FN_MIC_DET:  val = mic_detect_in;
                    FN_MIC_SHRT: val = mic_short_in;
                    default:     drv = 1'b0;
                endcase
            end
            assign ded_pullup_out[g]   = pu;
            assign ded_pulldown_out[g] = pd;
            assign ded_pin_oe_out[g]   = free && drv;
            assign ded_pin_out[g]      = free && drv && val;
            assign deb_en[g]    = cfg[F_DEB];
            assign irq_en[g]    = cfg[F_IRQ];
            assign in_active[g] = sel == FN_INPUT;
        end
        for (g = 0; g < 2; g++) begin : g_sh
            localparam int B = (g == 0) ? SH_FIRST : SH_SECOND;
            assign deb_en[NDED+g]    = shared_input_config[B + SH_DEB];
            assign irq_en[NDED+g]    = shared_input_config[B + SH_IRQ];
            assign in_active[NDED+g] = shared_input_config[B + SH_ENA];
        end
        // ==================================================
        // input path per pin
        for (g = 0; g < NPIN; g++) begin : g_in
            logic       sync_a;
            logic       sync_b;
            logic       stable;
            logic [2:0] cnt;
            logic       st;
            assign pol_inv[g] = input_polarity[POL_BIT[g]];
            wire logic cur  = sync_b ^ pol_inv[g];
            wire logic det  = deb_en[g] ? stable : cur;
            wire logic set_ev = in_active[g] && !tris_all && det;
            always_ff @(posedge core_clk_in or posedge reset_in) begin
                if (reset_in) begin
                    sync_a <= 1'b0;
                    sync_b <= 1'b0;
                end else begin
                    sync_a <= raw_pin[g];
                    sync_b <= sync_a;
                end
            end
            always_ff @(posedge core_clk_in or posedge reset_in) begin
                if (reset_in) begin
                    stable <= 1'b0;
                    cnt    <= 3'd0;
                end else if (cur == stable) begin
                    cnt <= 3'd0;
                end else if (tick) begin
                    if (cnt == DEB_TICKS - 3'd1) begin
                        stable <= cur;
                        cnt    <= 3'd0;
                    end else begin
                        cnt <= cnt + 3'd1;
                    end
                end
            end
            // latch detect, set beats read clear
            always_ff @(posedge core_clk_in or posedge reset_in) begin
                if (reset_in) begin
                    st <= 1'b0;
                end else if (set_ev) begin
                    st <= 1'b1;
                end else if (rd_st) begin
                    st <= 1'b0;
                end
            end
            assign irq_status[g] = st;
        end
    endgenerate

    // ==================================================
    // interrupt output
    // per-pin irq enable
    wire logic [NPIN-1:0] irq_pending = irq_status & irq_mask & irq_en;
    // high while any status bit is set whose mask bit and pin irq enable are both set
    assign irq_out = |irq_pending;

endmodule : mfpc_top

// File: mfpc_button_model.sv
// model of the buttons and accessory lines facing the pins
`timescale 1ns/1ps
module mfpc_button_model (
    // clock
    input  wire logic       clk_in,
    // presses from the bench: 0..2 dedicated, 3..4 shared
    input  wire logic [4:0] press_in,
    // device pad controls
    input  wire logic [2:0] pad_drive_in,
    input  wire logic [2:0] pad_oe_in,
    input  wire logic [2:0] pad_pu_in,
    input  wire logic [2:0] pad_pd_in,
    // resolved line levels
    output logic      [2:0] ded_level_out,
    output logic      [1:0] shared_level_out
);
    logic flip = 1'b0;

    // a floating line wanders every cycle
    always @(posedge clk_in) begin
        flip <= ~flip;
    end

    // pin drive, then press, then pull, else floating
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            ded_level_out[i] = pad_oe_in[i] ? pad_drive_in[i] :
                press_in[i] | pad_pu_in[i] | (~pad_pd_in[i] & flip);
        end
    end

    // shared lines: digital only, no pulls
    assign shared_level_out = press_in[4:3];
endmodule : mfpc_button_model

// File: mfpc_assertions.sv
// assertion checker for the pin control block
`timescale 1ns/1ps
module mfpc_checker
    import mfpc_pkg::*;
(
    // clock and reset
    input wire logic              core_clk_in,
    input wire logic              reset_in,
    // register bus
    input wire logic [ADDR_W-1:0] avs_address_in,
    input wire logic              avs_read_in,
    input wire logic              avs_write_in,
    input wire logic [31:0]       avs_readdata_out,
    // pins and interrupt
    input wire logic [NDED-1:0]   ded_pin_oe_out,
    input wire logic [NDED-1:0]   ded_pullup_out,
    input wire logic [NDED-1:0]   ded_pulldown_out,
    input wire logic              audio_pad_tristate_out,
    input wire logic              irq_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (reset_in);
    wire [7:0] idx    = avs_address_in[ADDR_W-1:2];
    wire       pad_wr = avs_write_in && idx == REG_IDX_PAD;
    wire       cfg_wr = avs_write_in &&
                        (idx == REG_IDX_CFG_A || idx == REG_IDX_CFG_B);
    wire       pol_rd = avs_read_in && idx == REG_IDX_POL;

    AST_TRIS_OE: assert property (
        audio_pad_tristate_out |-> !ded_pin_oe_out)
        else $error("pin driven while pads tristated");
    AST_TRIS_WR: assert property (
        $changed(audio_pad_tristate_out) |-> $past(pad_wr))
        else $error("tristate changed without pad write");
    AST_PULL_OE: assert property (
        ((ded_pullup_out | ded_pulldown_out) & ded_pin_oe_out) == '0)
        else $error("pulled pin is driven");
    AST_PD_RESET: assert property (
        $fell(reset_in) |-> ded_pulldown_out == 3'h7)
        else $error("pulldowns not on after reset");
    AST_PULL_WR: assert property (
        $changed({ded_pullup_out, ded_pulldown_out}) |-> $past(cfg_wr))
        else $error("pull enables changed without config write");
    AST_OE_WR: assert property (
        $changed(ded_pin_oe_out) |-> $past(avs_write_in))
        else $error("pin drive changed without a write");
    AST_IRQ_FALL: assert property (
        $fell(irq_out) |-> $past(avs_read_in || avs_write_in))
        else $error("interrupt dropped without register access");
    AST_POL_RSV: assert property (
        pol_rd |-> (avs_readdata_out & 32'hffffff23) == '0)
        else $error("reserved polarity bits read nonzero");

    COV_IRQ: cover property ($rose(irq_out));
    COV_TRIS: cover property (audio_pad_tristate_out);
    COV_DRIVE: cover property (ded_pin_oe_out[0]);
endmodule : mfpc_checker

bind mfpc_top mfpc_checker u_chk (
    .core_clk_in, .reset_in, .avs_address_in, .avs_read_in,
    .avs_write_in, .avs_readdata_out, .ded_pin_oe_out, .ded_pullup_out,
    .ded_pulldown_out, .audio_pad_tristate_out, .irq_out);

// File: tb_top.sv
// self-checking bench for the pin control block
`timescale 1ns/1ps
module tb_top
    import mfpc_pkg::*;
;
    logic              core_clk_in = 1'b0;
    logic              reset_in = 1'b1;
    logic [ADDR_W-1:0] avs_address_in = '0;
    logic              avs_read_in = 1'b0;
    logic              avs_write_in = 1'b0;
    logic [31:0]       avs_writedata_in = '0;
    logic              slow_tick_in = 1'b0;
    logic [6:0]        src = 7'h55;
    logic [4:0]        press = 5'h00;
    logic [1:0]        tdiv = 2'b00;
    logic [9:0]        lv;
    logic [31:0]       avs_readdata_out;
    logic              avs_waitrequest_out, audio_pad_tristate_out, irq_out;
    logic [2:0]        ded_pin_in, ded_pin_out, ded_pin_oe_out;
    logic [2:0]        ded_pullup_out, ded_pulldown_out;
    logic [1:0]        shared_pin_in;
    int                fails = 0;
    int                n_checks = 0;
    int                pb [5] = '{2, 3, 4, 6, 7};
    logic [7:0]  ix [5] = '{REG_IDX_PAD, REG_IDX_CFG_A, REG_IDX_CFG_B,
                           REG_IDX_SHARED, REG_IDX_POL};
    logic [15:0] rv [5] = '{16'h0000, 16'h1010, 16'h0010, 16'h0000, 16'h0000};
    logic [15:0] rm [5] = '{16'hffff, 16'hffff, 16'h00ff, 16'h00dd, 16'h00dc};

    mfpc_top u_dut (
        .core_clk_in, .reset_in, .avs_address_in, .avs_read_in,
        .avs_write_in, .avs_writedata_in, .avs_byteenable_in(4'hf),
        .avs_readdata_out, .avs_waitrequest_out,
        .system_clock_div_in(src[0]), .pll_lock_in(src[1]),
        .temp_ok_in(src[2]), .readback_serial_out_in(src[3]),
        .device_irq_in(src[4]), .mic_detect_in(src[5]),
        .mic_short_in(src[6]), .slow_tick_in, .ded_pin_in, .ded_pin_out,
        .ded_pin_oe_out, .ded_pullup_out, .ded_pulldown_out,
        .shared_pin_in, .audio_pad_tristate_out, .irq_out);

    mfpc_button_model u_btn (
        .clk_in(core_clk_in), .press_in(press), .pad_drive_in(ded_pin_out),
        .pad_oe_in(ded_pin_oe_out), .pad_pu_in(ded_pullup_out),
        .pad_pd_in(ded_pulldown_out), .ded_level_out(ded_pin_in),
        .shared_level_out(shared_pin_in));

    initial begin
        forever #12.5 core_clk_in = ~core_clk_in;
    end

    always @(posedge core_clk_in) begin
        tdiv <= tdiv + 2'd1;
        slow_tick_in <= (tdiv == 2'd3);
    end

    task automatic give_verdict;
        if (fails == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict

    task automatic chk(input string what, input logic [15:0] e,
                       input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s exp %h got %h", what, e, g);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [15:0] d, output logic [15:0] q);
        int n;
        n = 0;
        avs_address_in   <= {a, 2'b00};
        avs_writedata_in <= {16'h0000, d};
        avs_write_in     <= wr;
        avs_read_in      <= ~wr;
        do begin
            @(posedge core_clk_in);
            n++;
        end while (avs_waitrequest_out !== 1'b0 && n < 50);
        q = avs_readdata_out[15:0];
        if (avs_waitrequest_out !== 1'b0) begin
            chk("waitrequest", 16'h0000, 16'(avs_waitrequest_out));
            give_verdict();
        end
        avs_write_in <= 1'b0;
        avs_read_in  <= 1'b0;
        @(posedge core_clk_in);
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [15:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] q;
        bus(1'b0, a, 16'h0000, q);
        chk($sformatf("reg %h", a), e, q);
    endtask : rd

    task automatic clr;
        logic [15:0] q;
        repeat (4) @(posedge core_clk_in);
        bus(1'b0, REG_IDX_STATUS, 16'h0000, q);
    endtask : clr

    task automatic wait_irq(input logic v, input int lim);
        int n;
        n = 0;
        while (irq_out !== v && n < lim) begin
            @(posedge core_clk_in);
            n++;
        end
        chk("irq", 16'(v), 16'(irq_out));
        if (irq_out !== v)
            give_verdict();
    endtask : wait_irq

    initial begin
        repeat (12) @(posedge core_clk_in);
        reset_in <= 1'b0;
        @(posedge core_clk_in);
        chk("pulldowns", 16'h0007, 16'(ded_pulldown_out));
        for (int i = 0; i < 5; i++) begin
            rd(ix[i], rv[i]);
            wr(ix[i], 16'hffff);
            rd(ix[i], rm[i]);
            wr(ix[i], rv[i]);
        end
        rd(8'h1f, 16'h0000);
        for (int s = 0; s < 2; s++) begin
            src <= s[0] ? 7'h2a : 7'h55;
            // software keeps to the defined codes
            for (int c = 0; c < 10; c++) begin
                wr(REG_IDX_CFG_A, {4'h0, c[3:0], 4'h0, c[3:0]});
                wr(REG_IDX_CFG_B, {12'h000, c[3:0]});
                lv = {src[6:1], 1'b1, 1'b0, src[0], 1'b0};
                chk("oe", {13'h0, {3{c > 0}}}, 16'(ded_pin_oe_out));
                if (c > 0)
                    chk("level", {13'h0, {3{lv[c]}}}, 16'(ded_pin_out));
            end
        end
        wr(REG_IDX_CFG_B, 16'h0010);
        wr(REG_IDX_CFG_A, 16'h1023);
        chk("pull oe", 16'h0000, 16'(ded_pin_oe_out[0]));
        chk("pullup", 16'h0001, 16'(ded_pullup_out[0]));
        wr(REG_IDX_CFG_A, 16'h1003);
        wr(REG_IDX_PAD, 16'h2000);
        chk("tris oe", 16'h0000, 16'(ded_pin_oe_out[0]));
        chk("tris", 16'h0001, 16'(audio_pad_tristate_out));
        wr(REG_IDX_PAD, 16'h0000);
        chk("free oe", 16'h0001, 16'(ded_pin_oe_out[0]));
        wr(REG_IDX_MASK, 16'h001f);
        wr(REG_IDX_CFG_A, 16'h1050);
        clr;
        press <= 5'b00001;
        repeat (3) @(posedge core_clk_in);
        chk("irq early", 16'h0000, 16'(irq_out));
        wait_irq(1'b1, 10);
        wr(REG_IDX_MASK, 16'h0000);
        chk("irq masked", 16'h0000, 16'(irq_out));
        wr(REG_IDX_MASK, 16'h001f);
        chk("irq unmasked", 16'h0001, 16'(irq_out));
        press <= 5'b00000;
        clr;
        rd(REG_IDX_STATUS, 16'h0000);
        wr(REG_IDX_POL, 16'h0004);
        wait_irq(1'b1, 10);
        wr(REG_IDX_POL, 16'h0000);
        clr;
        // polarity map, one input at a time
        wr(REG_IDX_SHARED, 16'h0011);
        for (int p = 0; p < 5; p++) begin
            wr(REG_IDX_POL, 16'h0001 << pb[p]);
            rd(REG_IDX_STATUS, 16'h0001 << p);
            wr(REG_IDX_POL, 16'h0000);
            clr;
        end
        wr(REG_IDX_SHARED, 16'h0004);
        press <= 5'b01000;
        repeat (10) @(posedge core_clk_in);
        chk("shared off", 16'h0000, 16'(irq_out));
        wr(REG_IDX_SHARED, 16'h0005);
        wait_irq(1'b1, 10);
        press <= 5'b00000;
        wr(REG_IDX_SHARED, 16'h0000);
        clr;
        wr(REG_IDX_CFG_A, 16'h10d0);
        press <= 5'b00001;
        repeat (30) @(posedge core_clk_in);
        chk("no tick", 16'h0000, 16'(irq_out));
        wr(REG_IDX_MISC, 16'h0001);
        wait_irq(1'b1, 100);
        give_verdict();
    end
endmodule : tb_top
